// ---- rtl/nv_config_boot_security_ctrl.sv ----
// applies non-volatile configuration bits: security, supply drop detector, boot map
`timescale 1ns/1ps
module nv_config_boot_security_ctrl
   import nv_config_pkg::*;
(
   // clock and reset
   input wire logic clock,
   input wire logic arst_n,
   // non-volatile storage image, stable copy read out after power-up
   input wire logic [NV_BITS-1:0] nv_stored_bits,
   input wire logic nv_stored_valid,
   output logic nv_write_en,
   output logic [NV_BITS-1:0] nv_write_bits,
   // set and clear commands from the flash controller
   input wire logic cmd_set,
   input wire logic cmd_clear,
   input wire logic [1:0] cmd_index,
   input wire logic full_erase_done,
   // erase pin
   input wire logic erase_pin,
   // flash access requests
   input wire logic flash_req,
   input wire logic flash_req_debug,
   input wire logic flash_req_write,
   output logic flash_grant,
   output logic flash_refused,
   output logic flash_data_mask,
   // supply drop detector and reset controller
   input wire logic supply_drop_detected,
   output logic supply_drop_detector_en,
   output logic supply_drop_reset_req,
   // bus matrix decode
   input wire logic remap,
   input wire logic [31:0] fetch_addr,
   output logic [1:0] boot_map,
   output logic in_boot_region,
   output logic [31:0] reset_vector,
   output logic slow_clock_sel,
   input wire logic clock_switched,
   // visible state
   output logic [NV_BITS-1:0] nv_config_bit
);
   logic erase_meta_ff, erase_sync_ff, erase_armed_ff;
   logic [NV_BITS-1:0] bits_ff;
   logic boot_sel_ff, loaded_ff, slow_ff;
   logic nxt_write;
   logic [NV_BITS-1:0] nxt_bits;
   logic drop_meta_ff, drop_sync_ff;

   // erase pin comes from outside; two flops before use
   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         erase_meta_ff <= 1'b0;
         erase_sync_ff <= 1'b0;
      end
      else
      begin
         erase_meta_ff <= erase_pin;
         erase_sync_ff <= erase_meta_ff;
      end
   end

   // drop detector output is analog and unclocked; two flops before use
   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         drop_meta_ff <= 1'b0;
         drop_sync_ff <= 1'b0;
      end
      else
      begin
         drop_meta_ff <= supply_drop_detected;
         drop_sync_ff <= drop_meta_ff;
      end
   end

   always_comb
   begin
      nxt_bits = bits_ff;
      nxt_write = 1'b0;
      if (erase_armed_ff && full_erase_done)
      begin
         nxt_bits = NV_ERASED;
         nxt_write = 1'b1;
      end
      else if (cmd_set)
      begin
         nxt_bits[cmd_index] = 1'b1;
         nxt_write = 1'b1;
      end
      else if (cmd_clear && cmd_index != 2'(SECURITY_POS))
      begin
         // security cannot be cleared by command, only by erase sequence
         nxt_bits[cmd_index] = 1'b0;
         nxt_write = 1'b1;
      end
      // erase pin applied last so a command in the same cycle cannot undo it
      if (erase_sync_ff)
      begin
         nxt_bits[SUPPLY_EN_POS] = 1'b0;
         nxt_bits[SUPPLY_RST_POS] = 1'b0;
         nxt_write = 1'b1;
      end
      // skip writes that change nothing; every program wears the storage
      if (nxt_bits == bits_ff)
         nxt_write = 1'b0;
   end

   // erase pin arms the full-erase path; kept until an erase completes while the synchronised pin is low
   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
         erase_armed_ff <= 1'b0;
      else if (erase_sync_ff)
         erase_armed_ff <= 1'b1;
      else if (full_erase_done)
         erase_armed_ff <= 1'b0;
   end

   // working copy loaded once from storage, then tracks every change
   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         bits_ff <= NV_RESET;
         loaded_ff <= 1'b0;
      end
      else if (!loaded_ff)
      begin
         if (nv_stored_valid)
         begin
            bits_ff <= nv_stored_bits;
            loaded_ff <= 1'b1;
         end
      end
      else
         bits_ff <= nxt_bits;
   end

   // every change is written back so it survives power loss
   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         nv_write_en <= 1'b0;
         nv_write_bits <= NV_RESET;
      end
      else
      begin
         nv_write_en <= loaded_ff & nxt_write;
         nv_write_bits <= nxt_bits;
      end
   end

   // boot select frozen at the load after reset; later writes wait for next reset
   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
         boot_sel_ff <= 1'b0;
      else if (!loaded_ff && nv_stored_valid)
         boot_sel_ff <= nv_stored_bits[BOOT_SEL_POS];
   end

   // core starts on the slow clock; software moves it off later
   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
         slow_ff <= 1'b1;
      else if (clock_switched)
         slow_ff <= 1'b0;
   end

   // access gating; debug flash access is refused while the security bit is set or not yet loaded
   logic secure;
   assign secure = bits_ff[SECURITY_POS] | ~loaded_ff;
   assign flash_refused = flash_req & flash_req_debug & secure;
   assign flash_grant = flash_req & ~flash_refused;
   // data masked and writes dropped on a refused access
   assign flash_data_mask = flash_refused | (flash_req_write & flash_refused);

   assign supply_drop_detector_en = loaded_ff & bits_ff[SUPPLY_EN_POS];
   // request lags the detector by the two synchroniser cycles
   assign supply_drop_reset_req = supply_drop_detector_en & bits_ff[SUPPLY_RST_POS]
      & drop_sync_ff;

   // remap overrides the boot select frozen at load
   always_comb
   begin
      if (remap)
         boot_map = MAP_SRAM;
      else if (boot_sel_ff)
         boot_map = MAP_FLASH;
      else
         boot_map = MAP_ROM;
   end

   // only the boot region moves; other memories keep fixed bases
   assign in_boot_region = fetch_addr <= BOOT_REGION_TOP;
   assign reset_vector = BOOT_ADDR;
   assign slow_clock_sel = slow_ff;
   assign nv_config_bit = bits_ff;
endmodule

// ---- rtl/nv_config_pkg.sv ----
// constants for the non-volatile configuration loader
package nv_config_pkg;
   localparam int NV_BITS = 4;
   localparam int SECURITY_POS = 0;
   localparam int SUPPLY_EN_POS = 1;
   localparam int SUPPLY_RST_POS = 2;
   localparam int BOOT_SEL_POS = 3;
   // erased flash state: every configuration bit clear
   localparam logic [3:0] NV_ERASED = 4'h0;
   localparam logic [3:0] NV_RESET = 4'h0;
   localparam logic [31:0] BOOT_REGION_TOP = 32'h0FFF_FFFF;
   localparam logic [31:0] BOOT_ADDR = 32'h0000_0000;
   localparam int SLOW_CLOCK_HZ = 32768;
   typedef enum logic [1:0] {MAP_ROM, MAP_FLASH, MAP_SRAM} map_type;
   typedef enum logic [1:0] {LD_IDLE, LD_RUN} load_type;
endpackage

// ---- tb/nv_chk.sv ----
// loader port checks
`timescale 1ns/1ps
module nv_chk
   import nv_config_pkg::*;
(
   input wire logic clock, arst_n, flash_req, flash_req_debug, flash_grant, remap,
   input wire logic full_erase_done, supply_drop_detected, supply_drop_detector_en,
   input wire logic supply_drop_reset_req, erase_pin, in_boot_region, flash_data_mask,
   input wire logic [3:0] nv_config_bit,
   input wire logic [1:0] boot_map,
   input wire logic [31:0] reset_vector, fetch_addr
);
   default clocking @(posedge clock); endclocking
   default disable iff (!arst_n);
   a_dbg_block: assert property (
      flash_req && flash_req_debug && nv_config_bit[0] |-> !flash_grant)
      else $error("granted");
   a_sec_hold: assert property ($fell(nv_config_bit[0]) |-> $past(full_erase_done))
      else $error("cleared");
   a_det_follow: assert property (supply_drop_detector_en == nv_config_bit[1])
      else $error("detector");
   a_rst_gate: assert property (
      supply_drop_reset_req |-> $past(supply_drop_detected, 2) && nv_config_bit[2])
      else $error("reset");
   a_erase_clr: assert property (erase_pin [*3] |=> nv_config_bit[2:1] == 2'h0)
      else $error("erase");
   a_remap_sram: assert property (remap |-> boot_map == MAP_SRAM) else $error("map");
   a_vec_zero: assert property (reset_vector == BOOT_ADDR) else $error("vector");
   a_region_top: assert property (in_boot_region == (fetch_addr <= BOOT_REGION_TOP))
      else $error("region");
   cover property (flash_req_debug && flash_data_mask);
   cover property (supply_drop_reset_req);
   cover property (remap);
   cover property ($fell(nv_config_bit[0]));
endmodule

// ---- tb/nv_store_model.sv ----
// nonvolatile image, kept through power loss
`timescale 1ns/1ps
module nv_store_model
(
   input wire logic clock, powered, nv_write_en,
   input wire logic [3:0] nv_write_bits,
   output logic [3:0] nv_stored_bits,
   output logic nv_stored_valid
);
   logic [3:0] mem_ff = 4'h0;
   // image changes only through the loader's own writes
   always @(posedge clock)
      mem_ff <= nv_write_en ? nv_write_bits : mem_ff;
   // unpowered lines carry garbage, not the image
   assign nv_stored_valid = powered;
   assign nv_stored_bits = powered ? mem_ff : ~mem_ff;
endmodule

// ---- tb/tb.sv ----
// loader bench
`timescale 1ns/1ps
module tb;
   import nv_config_pkg::*;
   logic clock = 0, arst_n = 0, powered = 0, cmd_set = 0, cmd_clear = 0, erase_pin = 0;
   logic full_erase_done = 0, flash_req = 1, flash_req_debug = 1, flash_req_write = 0;
   logic supply_drop_detected = 0, remap = 0, clock_switched = 0, nv_write_en, flash_grant;
   logic nv_stored_valid, flash_refused, flash_data_mask, supply_drop_detector_en;
   logic supply_drop_reset_req, in_boot_region, slow_clock_sel;
   logic [1:0] cmd_index = 0, boot_map;
   logic [3:0] nv_stored_bits, nv_write_bits, nv_config_bit;
   logic [31:0] fetch_addr = 32'h1000_0000, reset_vector;
   int error_cnt = 0, tests_run = 0;
   always #2.5 clock = ~clock;
   nv_config_boot_security_ctrl nv_config_boot_security_ctrl_inst (.*);
   nv_store_model nv_store_model_inst (.*);
   task chk(input logic [31:0] seen, exp);
      tests_run++;
      error_cnt += int'(seen !== exp);
      if (seen !== exp)
         $display("BAD %0t %h %h", $time, seen, exp);
   endtask
   task cmd(input logic s, input logic [1:0] i, input logic e);
      @(posedge clock) {cmd_set, cmd_clear, cmd_index} <= {s, !s, i};
      @(posedge clock) {cmd_set, cmd_clear} <= 2'h0;
      #1 chk(nv_config_bit[i], e);
   endtask
   task rst();
      @(posedge clock) {powered, arst_n} <= 2'h0;
      repeat (2) @(posedge clock);
      {powered, arst_n} <= 2'h3;
      @(posedge clock) #1;
   endtask
   task t_cmds();
      chk({boot_map, slow_clock_sel, flash_grant}, {MAP_ROM, 2'h3});
      chk(reset_vector, BOOT_ADDR);
      chk(in_boot_region, 0);
      @(posedge clock) {fetch_addr, clock_switched} <= {BOOT_REGION_TOP, 1'b1};
      @(posedge clock) clock_switched <= 0;
      #1 chk({in_boot_region, slow_clock_sel}, 2'h2);
      for (int i = 0; i < 4; i++)
         cmd(1, i[1:0], 1);
      @(posedge clock) full_erase_done <= 1;
      @(posedge clock) full_erase_done <= 0;
      #1 chk(nv_config_bit[0], 1);
      @(posedge clock) {remap, supply_drop_detected, flash_req_write} <= 3'h7;
      repeat (2) @(posedge clock);
      #1 chk({flash_refused, flash_data_mask, flash_grant}, 3'h6);
      chk({supply_drop_detector_en, supply_drop_reset_req}, 2'h3);
      chk(boot_map, MAP_SRAM);
      cmd(0, 0, 1);
      cmd(0, 1, 0);
      chk({supply_drop_detector_en, supply_drop_reset_req}, 2'h0);
      @(posedge clock) remap <= 0;
      $display("cmds done");
   endtask
   task t_erase();
      rst();
      chk({nv_config_bit, boot_map}, {4'hD, MAP_FLASH});
      chk(slow_clock_sel, 1);
      @(posedge clock) erase_pin <= 1;
      repeat (4) @(posedge clock);
      full_erase_done <= 1;
      #1 chk(nv_config_bit[2:0], 3'h1);
      @(posedge clock) full_erase_done <= 0;
      #1 chk({nv_config_bit[2:0], flash_grant, flash_data_mask}, 5'h2);
      $display("erase done");
   endtask
   task report_and_stop();
      $display("checks %0d bad %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   initial
   begin
      rst();
      t_cmds();
      t_erase();
      report_and_stop();
   end
endmodule
bind nv_config_boot_security_ctrl nv_chk nv_chk_inst (.*);
